// *** src/fdu_pkg.sv ***
// fdu_pkg: layouts, latencies and encodings
// assumes: imported whole by every design file of the block
package fdu_pkg;
  // operand layouts
  localparam int SP_W = 32;
  localparam int SP_EXP_W = 8;
  localparam int SP_SIG_W = 24;
  localparam int DP_W = 64;
  localparam int DP_EXP_W = 11;
  localparam int DP_SIG_W = 53;
  localparam int SP_BIAS = 127;
  localparam int DP_BIAS = 1023;
  localparam int SP_EMIN = -126;
  localparam int DP_EMIN = -1022;
  localparam int EXP_OUT_W = 12;
  localparam int DP_WIDE_LSB_W = 29;
  // execution latencies in cycles
  localparam int LAT_W = 5;
  localparam logic [4:0] LAT_ARITH = 5'h06;
  localparam logic [4:0] LAT_CVT = 5'h04;
  localparam logic [4:0] LAT_OTHER = 5'h02;
  localparam logic [4:0] DIV_MIN = 5'h04;
  localparam logic [4:0] DIV_MID = 5'h0a;
  localparam logic [4:0] DIV_MAX = 5'h10;
  localparam logic [4:0] SQRT_MIN = 5'h04;
  localparam logic [4:0] SQRT_MID = 5'h10;
  localparam logic [4:0] SQRT_MAX = 5'h1f;
  // structure
  localparam int PIPE_D = 6;
  localparam int TAG_W = 8;
  localparam int NU = 2;
  localparam int NL = 3;
  localparam int NC = 4;
  localparam logic U_FULL = 1'b0;
  localparam logic [1:0] LN_L2 = 2'h0;
  localparam logic [1:0] LN_L4 = 2'h1;
  localparam logic [1:0] LN_L6 = 2'h2;
  localparam logic [1:0] LN_DS = 2'h3;
  localparam logic [2:0] W_NONE = 3'h4;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_MUL = 4'h2, OP_MADD = 4'h3, OP_MSUB = 4'h4,
    OP_CVT = 4'h5, OP_DIV = 4'h6, OP_SQRT = 4'h7, OP_MEDIA = 4'h8, OP_OTHER = 4'h9
  } fdu_op_t;
  typedef enum logic [1:0] {FMT_S = 2'h0, FMT_D = 2'h1, FMT_PS = 2'h2} fdu_fmt_t;
  typedef enum logic [2:0] {
    CLS_ZERO = 3'h0, CLS_SUB = 3'h1, CLS_NORM = 3'h2, CLS_INF = 3'h3,
    CLS_SNAN = 3'h4, CLS_QNAN = 3'h5
  } fdu_cls_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_RUN = 4'h2, ST_RUN_PEND = 4'h4, ST_LAUNCH = 4'h8
  } fdu_ds_t;
endpackage

// *** src/fdu_classify.sv ***
// fdu_classify: decodes one 64-bit register word into operand classes
// assumes: pure combinational, word and format valid together
`timescale 1ns/1ps
module fdu_classify
  import fdu_pkg::*;
(
  input logic [63:0] word,
  input fdu_fmt_t fmt,
  output fdu_cls_t cls_lo,
  output fdu_cls_t cls_hi,
  output logic [11:0] exp_lo,
  output logic wide
);
  // class from exponent and fraction shape
  function automatic fdu_cls_t cls_of(input logic e_zero, input logic e_ones,
                                      input logic f_zero, input logic f_msb);
    if (e_zero)
      cls_of = f_zero ? CLS_ZERO : CLS_SUB; // RULE6
    else if (e_ones)
      cls_of = f_zero ? CLS_INF : (f_msb ? CLS_SNAN : CLS_QNAN); // RULE7 RULE8
    else
      cls_of = CLS_NORM; // RULE5
  endfunction

  // single lane: sign, 8-bit exponent, 23 stored fraction bits
  function automatic fdu_cls_t cls_sp(input logic [31:0] w);
    cls_sp = cls_of(w[30:23] == 8'h00, &w[30:23], w[22:0] == 23'h0, w[22]); // RULE1
  endfunction

  // decode per format
  always_comb begin
    if (fmt == FMT_D) begin
      cls_lo = cls_of(word[62:52] == 11'h000, &word[62:52], word[51:0] == 52'h0,
                      word[51]); // RULE2
      cls_hi = cls_lo;
      if (word[62:52] == 11'h000)
        exp_lo = 12'(DP_EMIN); // RULE6
      else
        exp_lo = 12'(int'(word[62:52]) - DP_BIAS); // RULE4
      wide = |word[DP_WIDE_LSB_W-1:0];
    end else begin
      cls_lo = cls_sp(word[31:0]);
      cls_hi = (fmt == FMT_PS) ? cls_sp(word[63:32]) : cls_lo; // RULE3
      if (word[30:23] == 8'h00)
        exp_lo = 12'(SP_EMIN); // RULE6
      else
        exp_lo = 12'(int'(word[30:23]) - SP_BIAS); // RULE4
      wide = 1'b0;
    end
  end
endmodule

// *** src/fdu_iter.sv ***
// fdu_iter: latency counter of the iterative divide and square root
// assumes: start only while idle, lat of at least 2
`timescale 1ns/1ps
module fdu_iter
  import fdu_pkg::*;
(
  input logic clock,
  input logic rstn,
  input logic start,
  input logic [4:0] lat,
  output logic done
);
  logic [4:0] cnt_reg;
  logic done_reg;

  // count down, done registered as the count reaches zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_reg <= 5'h00;
      done_reg <= 1'b0;
    end else begin
      done_reg <= (cnt_reg == 5'h01);
      if (start)
        cnt_reg <= lat - 5'h01;
      else if (cnt_reg != 5'h00)
        cnt_reg <= cnt_reg - 5'h01;
    end
  end

  assign done = done_reg;
endmodule

// *** src/fdu_exec.sv ***
// fdu_exec: two fp units, one issue port, write-back
// assumes: issuer obeys ready and stall
//
// Behaviour
// [RULE1] single: 32 bits, 8 exp, 24 sig
// [RULE2] double: 64 bits, 11 exp, 53 sig
// [RULE3] paired single: two singles per word
// [RULE4] stored exponent is true plus bias
// [RULE5] in-range exponent: normal, hidden one
// [RULE6] min minus one: zero or subnormal
// [RULE7] max plus one: infinity or NaN
// [RULE8] fraction msb set: signalling NaN
// [RULE9] execute split two to six stages
// [RULE10] full unit all ops, second a subset
// [RULE11] per unit one issue, one result
// [RULE12] add, multiply, fused take six
// [RULE13] conversions take four
// [RULE14] divide takes four to sixteen
// [RULE15] root takes four to thirty-one
// [RULE16] other ops take two
// [RULE17] same-cycle finish: shorter latency wins
// [RULE18] all but divide, root pipelined
// [RULE19] second divide or root stalls issue
// [RULE20] fused multiply-add rounds once
// [RULE21] losing result held, written later
`timescale 1ns/1ps
module fdu_exec
  import fdu_pkg::*;
(
  input logic clock,
  input logic rstn,
  input logic issue_valid,
  input fdu_op_t issue_op,
  input fdu_fmt_t issue_fmt,
  input logic [7:0] issue_tag,
  input logic [63:0] issue_a,
  input logic [63:0] issue_b,
  output logic issue_ready,
  output logic stall,
  output logic wb_full_valid,
  output logic [7:0] wb_full_tag,
  output logic wb_am_valid,
  output logic [7:0] wb_am_tag,
  output fdu_cls_t a_cls_lo,
  output fdu_cls_t a_cls_hi,
  output logic [11:0] a_exp_lo,
  output fdu_cls_t b_cls_lo
);
  // ----------------
  // decode helpers
  // ----------------
  // latency lane of an operation
  function automatic logic [1:0] lane_of(input fdu_op_t op);
    unique case (op)
      OP_ADD, OP_SUB, OP_MUL, OP_MADD, OP_MSUB: lane_of = LN_L6;
      OP_CVT: lane_of = LN_L4;
      OP_DIV, OP_SQRT: lane_of = LN_DS;
      default: lane_of = LN_L2;
    endcase
  endfunction

  // fixed latency of a pipelined lane
  function automatic logic [4:0] lane_lat(input logic [1:0] l);
    unique case (l)
      LN_L6: lane_lat = LAT_ARITH; // RULE12
      LN_L4: lane_lat = LAT_CVT; // RULE13
      default: lane_lat = LAT_OTHER; // RULE16
    endcase
  endfunction

  // entry stage, so every lane leaves at the last stage
  function automatic int lane_start(input logic [1:0] l);
    lane_start = PIPE_D - int'(lane_lat(l)); // RULE9
  endfunction

  // operations the add-multiply unit cannot run
  function automatic logic full_only(input fdu_op_t op);
    full_only = (op == OP_CVT) || (op == OP_DIV) || (op == OP_SQRT) || (op == OP_OTHER);
  endfunction

  // zero, infinity and NaN finish early in the iteration
  function automatic logic quick(input fdu_cls_t c);
    quick = (c != CLS_NORM) && (c != CLS_SUB);
  endfunction

  // operand-dependent iteration length
  function automatic logic [4:0] ds_lat_of(input fdu_op_t op, input fdu_cls_t ca,
                                           input fdu_cls_t cb, input logic wa,
                                           input logic wb);
    if (op == OP_DIV) begin
      if (quick(ca) || quick(cb))
        ds_lat_of = DIV_MIN; // RULE14
      else
        ds_lat_of = (wa || wb) ? DIV_MAX : DIV_MID; // RULE14
    end else begin
      if (quick(ca))
        ds_lat_of = SQRT_MIN; // RULE15
      else
        ds_lat_of = wa ? SQRT_MAX : SQRT_MID; // RULE15
    end
  endfunction

  // lowest latency among valid candidates, W_NONE if none
  function automatic logic [2:0] pick(input logic [3:0] v, input logic [19:0] lats);
    logic [2:0] best;
    logic [4:0] blat;
    best = W_NONE;
    blat = 5'h1f;
    for (int l = 0; l < NC; l++) begin
      if (v[l] && ((best == W_NONE) || (lats[l*LAT_W +: LAT_W] < blat))) begin
        best = 3'(l);
        blat = lats[l*LAT_W +: LAT_W];
      end
    end
    pick = best;
  endfunction

  // ----------------
  // state
  // ----------------
  logic issue_ready_reg;
  logic stall_reg;
  logic tgl_reg;
  logic pv_reg [NU][NL][PIPE_D];
  logic [TAG_W-1:0] pt_reg [NU][NL][PIPE_D];
  logic hv_reg [NU][NC];
  logic hv_next [NU][NC];
  logic [TAG_W-1:0] ht_reg [NU][NC];
  logic [4:0] ds_hlat_reg;
  logic wbv_reg [NU];
  logic [TAG_W-1:0] wbt_reg [NU];
  fdu_ds_t state_reg;
  fdu_ds_t state_next;
  logic [4:0] ds_lat_reg;
  logic [TAG_W-1:0] ds_tag_reg;
  logic [4:0] pend_lat_reg;
  logic [TAG_W-1:0] pend_tag_reg;
  fdu_cls_t a_cls_lo_reg;
  fdu_cls_t a_cls_hi_reg;
  fdu_cls_t b_cls_lo_reg;
  logic [11:0] a_exp_lo_reg;

  logic acc;
  logic [1:0] in_lane;
  logic in_unit;
  logic ds_in;
  logic ds_done;
  logic ds_go;
  logic [4:0] go_lat;
  logic [TAG_W-1:0] go_tag;
  logic [4:0] new_lat;
  logic stall_next;
  logic any_hold;
  fdu_cls_t ca_lo;
  fdu_cls_t ca_hi;
  fdu_cls_t cb_lo;
  fdu_cls_t cb_hi;
  logic [11:0] ca_exp;
  logic [11:0] cb_exp;
  logic ca_wide;
  logic cb_wide;
  logic tv [NU][NC];
  logic [TAG_W-1:0] tt [NU][NC];
  logic [NC-1:0] cv [NU];
  logic [TAG_W-1:0] ct [NU][NC];
  logic [NC*LAT_W-1:0] cl [NU];
  logic [2:0] win [NU];
  logic frz [NU][NL];

  // ----------------
  // operand decode and issue steering
  // ----------------
  fdu_classify u_cls_a (
    .word(issue_a),
    .fmt(issue_fmt),
    .cls_lo(ca_lo),
    .cls_hi(ca_hi),
    .exp_lo(ca_exp),
    .wide(ca_wide)
  );

  fdu_classify u_cls_b (
    .word(issue_b),
    .fmt(issue_fmt),
    .cls_lo(cb_lo),
    .cls_hi(cb_hi),
    .exp_lo(cb_exp),
    .wide(cb_wide)
  );

  // one accepted instruction per cycle, sent to exactly one unit
  assign acc = issue_valid & issue_ready_reg; // RULE11
  assign in_lane = lane_of(issue_op);
  assign in_unit = full_only(issue_op) ? U_FULL : tgl_reg; // RULE10
  assign ds_in = acc & (in_lane == LN_DS);
  assign new_lat = ds_lat_of(issue_op, ca_lo, cb_lo, ca_wide, cb_wide);

  // shared ops alternate between the units
  always_ff @(posedge clock) begin
    if (!rstn)
      tgl_reg <= 1'b0;
    else if (acc && !full_only(issue_op))
      tgl_reg <= ~tgl_reg; // RULE10
  end

  // operand classes of the last accepted instruction
  always_ff @(posedge clock) begin
    if (!rstn) begin
      a_cls_lo_reg <= CLS_ZERO;
      a_cls_hi_reg <= CLS_ZERO;
      b_cls_lo_reg <= CLS_ZERO;
      a_exp_lo_reg <= 12'h000;
    end else if (acc) begin
      a_cls_lo_reg <= ca_lo; // RULE5
      a_cls_hi_reg <= ca_hi; // RULE3
      b_cls_lo_reg <= cb_lo;
      a_exp_lo_reg <= ca_exp; // RULE4
    end
  end

  // ----------------
  // pipelined lanes
  // ----------------
  // lanes shift unless the tail is blocked by its hold;
  // a fused op is one six-cycle lane op, one rounding
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int u = 0; u < NU; u++)
        for (int l = 0; l < NL; l++)
          for (int s = 0; s < PIPE_D; s++) begin
            pv_reg[u][l][s] <= 1'b0;
            pt_reg[u][l][s] <= '0;
          end
    end else begin
      for (int u = 0; u < NU; u++)
        for (int l = 0; l < NL; l++)
          if (!frz[u][l]) begin
            for (int s = 0; s < PIPE_D; s++) begin
              if (s == lane_start(2'(l))) begin
                pv_reg[u][l][s] <= acc && (in_unit == 1'(u)) && (in_lane == 2'(l)); // RULE18
                pt_reg[u][l][s] <= issue_tag; // RULE20
              end else if (s > lane_start(2'(l))) begin
                pv_reg[u][l][s] <= pv_reg[u][l][s-1];
                pt_reg[u][l][s] <= pt_reg[u][l][s-1];
              end else begin
                pv_reg[u][l][s] <= 1'b0;
                pt_reg[u][l][s] <= '0;
              end
            end
          end
    end
  end

  // ----------------
  // divide and square root sequencer
  // ----------------
  fdu_iter u_iter (
    .clock(clock),
    .rstn(rstn),
    .start(ds_go),
    .lat(go_lat),
    .done(ds_done)
  );

  // second op waits until the first leaves its hold
  always_comb begin
    state_next = state_reg;
    ds_go = 1'b0;
    go_lat = new_lat;
    go_tag = issue_tag;
    unique case (state_reg)
      ST_IDLE: begin
        if (ds_in) begin
          state_next = ST_RUN;
          ds_go = 1'b1;
        end
      end
      ST_RUN: begin
        if (ds_in)
          state_next = ds_done ? ST_LAUNCH : ST_RUN_PEND; // RULE19
        else if (ds_done)
          state_next = ST_IDLE;
      end
      ST_RUN_PEND: begin
        if (ds_done)
          state_next = ST_LAUNCH;
      end
      ST_LAUNCH: begin
        if (!hv_reg[0][LN_DS]) begin
          state_next = ST_RUN;
          ds_go = 1'b1;
          go_lat = pend_lat_reg;
          go_tag = pend_tag_reg;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // running and waiting op bookkeeping
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      ds_lat_reg <= 5'h00;
      ds_tag_reg <= '0;
      pend_lat_reg <= 5'h00;
      pend_tag_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (ds_go) begin
        ds_lat_reg <= go_lat; // RULE14 RULE15
        ds_tag_reg <= go_tag;
      end
      if ((state_reg == ST_RUN) && ds_in) begin
        pend_lat_reg <= new_lat;
        pend_tag_reg <= issue_tag;
      end
    end
  end

  // ----------------
  // write-back arbitration
  // ----------------
  // candidates: lane tails, holds, iterative op
  always_comb begin
    any_hold = 1'b0;
    for (int u = 0; u < NU; u++) begin
      for (int l = 0; l < NC; l++) begin
        if (l < NL) begin
          tv[u][l] = pv_reg[u][l][PIPE_D-1];
          tt[u][l] = pt_reg[u][l][PIPE_D-1];
          cl[u][l*LAT_W +: LAT_W] = lane_lat(2'(l));
        end else begin
          tv[u][l] = (u == 0) && ds_done;
          tt[u][l] = ds_tag_reg;
          cl[u][l*LAT_W +: LAT_W] = hv_reg[u][l] ? ds_hlat_reg : ds_lat_reg;
        end
        cv[u][l] = hv_reg[u][l] | tv[u][l];
        ct[u][l] = hv_reg[u][l] ? ht_reg[u][l] : tt[u][l];
      end
      win[u] = pick(cv[u], cl[u]); // RULE17
      for (int l = 0; l < NC; l++) begin
        if (win[u] == 3'(l))
          hv_next[u][l] = hv_reg[u][l] & tv[u][l]; // RULE21
        else
          hv_next[u][l] = hv_reg[u][l] | tv[u][l]; // RULE21
        any_hold = any_hold | hv_next[u][l];
      end
      for (int l = 0; l < NL; l++)
        frz[u][l] = hv_reg[u][l] & tv[u][l] & (win[u] != 3'(l)); // RULE21
    end
  end

  // losing tail moves into its hold
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int u = 0; u < NU; u++)
        for (int l = 0; l < NC; l++) begin
          hv_reg[u][l] <= 1'b0;
          ht_reg[u][l] <= '0;
        end
      ds_hlat_reg <= 5'h00;
    end else begin
      for (int u = 0; u < NU; u++)
        for (int l = 0; l < NC; l++) begin
          hv_reg[u][l] <= hv_next[u][l];
          if (tv[u][l] && (hv_reg[u][l] == (win[u] == 3'(l))))
            ht_reg[u][l] <= tt[u][l]; // RULE21
        end
      if (tv[0][LN_DS] && !hv_reg[0][LN_DS] && (win[0] != 3'(LN_DS)))
        ds_hlat_reg <= ds_lat_reg;
    end
  end

  // one result per unit per cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int u = 0; u < NU; u++) begin
        wbv_reg[u] <= 1'b0;
        wbt_reg[u] <= '0;
      end
    end else begin
      for (int u = 0; u < NU; u++) begin
        wbv_reg[u] <= (win[u] != W_NONE); // RULE11
        wbt_reg[u] <= (win[u] != W_NONE) ? ct[u][win[u][1:0]] : '0;
      end
    end
  end

  // ----------------
  // issue flow control
  // ----------------
  // stall until first iterative op writes back
  assign stall_next = (state_next == ST_RUN_PEND) ||
                      ((state_next == ST_LAUNCH) && hv_next[0][LN_DS]); // RULE19

  // ready low on stall, launch or any hold
  always_ff @(posedge clock) begin
    if (!rstn) begin
      stall_reg <= 1'b0;
      issue_ready_reg <= 1'b0;
    end else begin
      stall_reg <= stall_next; // RULE19
      issue_ready_reg <= !stall_next && (state_next != ST_LAUNCH) && !any_hold;
    end
  end

  assign issue_ready = issue_ready_reg;
  assign stall = stall_reg;
  assign wb_full_valid = wbv_reg[0];
  assign wb_full_tag = wbt_reg[0];
  assign wb_am_valid = wbv_reg[1];
  assign wb_am_tag = wbt_reg[1];
  assign a_cls_lo = a_cls_lo_reg;
  assign a_cls_hi = a_cls_hi_reg;
  assign a_exp_lo = a_exp_lo_reg;
  assign b_cls_lo = b_cls_lo_reg;
endmodule

// *** sim/fdu_exec_chk.sv ***
// fdu_exec_chk: port assertions
// assumes: bound to fdu_exec, unique tags
`timescale 1ns/1ps
module fdu_exec_chk
  import fdu_pkg::*;
(
  input logic clock,
  input logic rstn,
  input logic issue_valid,
  input fdu_op_t issue_op,
  input fdu_fmt_t issue_fmt,
  input logic [7:0] issue_tag,
  input logic [63:0] issue_a,
  input logic issue_ready,
  input logic stall,
  input logic wb_full_valid,
  input logic [7:0] wb_full_tag,
  input logic wb_am_valid,
  input logic [7:0] wb_am_tag,
  input fdu_cls_t a_cls_lo,
  input logic [11:0] a_exp_lo
);
  // ----------------
  // issue age bookkeeping
  // ----------------
  logic [15:0] cyc_reg;
  logic [15:0] born_reg [256];
  fdu_op_t op_reg [256];
  logic take;
  logic [15:0] age_f;
  logic [15:0] age_a;
  fdu_op_t op_f;
  fdu_op_t op_a;
  assign take = issue_valid && issue_ready;
  assign age_f = cyc_reg - born_reg[wb_full_tag];
  assign age_a = cyc_reg - born_reg[wb_am_tag];
  assign op_f = op_reg[wb_full_tag];
  assign op_a = op_reg[wb_am_tag];
  // free cycle count
  always_ff @(posedge clock) begin
    if (!rstn) cyc_reg <= 16'h0000;
    else cyc_reg <= cyc_reg + 16'h0001;
  end
  // birth cycle and op per tag
  always_ff @(posedge clock) begin
    if (take) begin
      born_reg[issue_tag] <= cyc_reg;
      op_reg[issue_tag] <= issue_op;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ----------------
  // assertions
  // ----------------
  a_arith_lat:
  assert property (wb_full_valid && op_f inside {OP_ADD, OP_SUB, OP_MUL, OP_MADD, OP_MSUB}
    |-> age_f >= 16'h0007 && age_f < 16'h0040) else $error("arith late");
  a_am_lat:
  assert property (wb_am_valid |-> age_a >= (op_a == OP_MEDIA ? 16'h0003 : 16'h0007)
    && age_a < 16'h0040) else $error("am late");
  a_am_subset:
  assert property (wb_am_valid |-> op_a inside {OP_ADD, OP_SUB, OP_MUL, OP_MADD, OP_MSUB,
    OP_MEDIA}) else $error("am ran full-only op");
  a_cvt_lat:
  assert property (wb_full_valid && op_f == OP_CVT |-> age_f >= 16'h0005 && age_f < 16'h0040)
    else $error("cvt late");
  a_short_lat:
  assert property (wb_full_valid && op_f inside {OP_MEDIA, OP_OTHER}
    |-> age_f >= 16'h0003 && age_f < 16'h0040) else $error("short late");
  a_div_lat:
  assert property (wb_full_valid && op_f == OP_DIV |-> age_f >= 16'h0005 && age_f < 16'h0080)
    else $error("div late");
  a_sqrt_lat:
  assert property (wb_full_valid && op_f == OP_SQRT |-> age_f >= 16'h0005 && age_f < 16'h0080)
    else $error("sqrt late");
  a_stall_rise:
  assert property (take && issue_op == OP_DIV ##1 take && issue_op == OP_DIV |=> stall)
    else $error("no stall");
  a_stall_ready:
  assert property (stall |-> !issue_ready) else $error("ready in stall");
  a_exp_bias:
  assert property (take && issue_fmt != FMT_D && issue_a[30:23] != 8'h00
    |=> a_exp_lo == {4'h0, $past(issue_a[30:23])} - 12'h07f) else $error("bias wrong");
  a_snan_msb:
  assert property (take && issue_fmt != FMT_D && issue_a[30:22] == 9'h1ff
    |=> a_cls_lo == CLS_SNAN) else $error("snan wrong");
  a_reset_quiet:
  assert property (@(posedge clock) disable iff (1'b0) !rstn
    |=> !issue_ready && !stall && !wb_full_valid && !wb_am_valid) else $error("reset loud");
endmodule

bind fdu_exec fdu_exec_chk chk_i (.*);

// *** sim/fdu_issuer.sv ***
// fdu_issuer: issue pipeline model
// assumes: bench fills the queue by push
`timescale 1ns/1ps
module fdu_issuer
  import fdu_pkg::*;
(
  input logic clock,
  input logic rstn,
  input logic slow,
  input logic issue_ready,
  input logic stall,
  output logic issue_valid,
  output fdu_op_t issue_op,
  output fdu_fmt_t issue_fmt,
  output logic [7:0] issue_tag,
  output logic [63:0] issue_a,
  output logic [63:0] issue_b
);
  logic [141:0] q [$];
  bit held = 1'b0;
  bit idle;
  task automatic push(input fdu_op_t op, input fdu_fmt_t fmt, input logic [7:0] tag,
                      input logic [63:0] a, input logic [63:0] b);
    q.push_back({op, fmt, tag, a, b});
  endtask
  // quiet outputs at time zero
  initial begin
    issue_valid = 1'b0;
    issue_op = OP_ADD;
    issue_fmt = FMT_S;
    issue_tag = 8'h00;
    issue_a = 64'h0;
    issue_b = 64'h0;
  end
  // present head, hold until taken, keep off while stalled
  always @(posedge clock) begin
    idle = 1'b0;
    if (held && issue_ready === 1'b1) begin
      void'(q.pop_front());
      held = 1'b0;
      idle = slow;
    end
    if (!rstn) begin
      held = 1'b0;
      issue_valid <= 1'b0;
    end else if (!held && !idle && stall !== 1'b1 && q.size() != 0) begin
      issue_op <= fdu_op_t'(q[0][141:138]);
      issue_fmt <= fdu_fmt_t'(q[0][137:136]);
      issue_tag <= q[0][135:128];
      issue_a <= q[0][127:64];
      issue_b <= q[0][63:0];
      issue_valid <= 1'b1;
      held = 1'b1;
    end else if (!held) begin
      issue_valid <= 1'b0;
      issue_a <= ~issue_a;
      issue_b <= ~issue_b;
    end
  end
endmodule

// *** sim/tb_top.sv ***
// tb_top: self-checking bench for fdu_exec
// assumes: fdu_issuer drives issue side
`timescale 1ns/1ps
module tb_top;
  import fdu_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic slow = 1'b0;
  logic issue_valid, issue_ready, stall, wb_full_valid, wb_am_valid;
  fdu_op_t issue_op;
  fdu_fmt_t issue_fmt;
  logic [7:0] issue_tag, wb_full_tag, wb_am_tag, t;
  logic [63:0] issue_a, issue_b;
  fdu_cls_t a_cls_lo, a_cls_hi, b_cls_lo, e_alo, e_ahi, e_blo;
  logic [11:0] a_exp_lo, e_exp;
  int err_count = 0, check_count = 0, cyc = 0, npend = 0;
  int lat [256], late [256], due [256], tk [256];
  bit pend [256], exact [256], uexp [256];
  bit tog = 1'b0, cls_pend = 1'b0, saw_stall = 1'b0;
  logic [7:0] tag_n = 8'h00;
  logic [31:0] sv [6] = '{32'h00000000, 32'h00000001, 32'h3f800000, 32'h7f800000,
                          32'h7fc00000, 32'h7f800001};
  logic [63:0] dv [4] = '{64'h3ff0000000000000, 64'h3ff0000000000001, 64'h7ff8000000000000,
                          64'h0000000000000001};
  always #12.5 clock = ~clock;
  fdu_issuer iss (.clock, .rstn, .slow, .issue_ready, .stall, .issue_valid, .issue_op,
    .issue_fmt, .issue_tag, .issue_a, .issue_b);
  fdu_exec dut (.clock, .rstn, .issue_valid, .issue_op, .issue_fmt, .issue_tag, .issue_a,
    .issue_b, .issue_ready, .stall, .wb_full_valid, .wb_full_tag, .wb_am_valid, .wb_am_tag,
    .a_cls_lo, .a_cls_hi, .a_exp_lo, .b_cls_lo);
  // ----------------
  // expectation helpers
  // ----------------
  function automatic fdu_cls_t cls_f(input logic [63:0] w, input bit d);
    logic [10:0] e;
    logic [51:0] f;
    e = d ? w[62:52] : {3'h0, w[30:23]};
    f = d ? w[51:0] : {29'h0, w[22:0]};
    if (e == 11'h000) return (f == 52'h0) ? CLS_ZERO : CLS_SUB;
    if (e != (d ? 11'h7ff : 11'h0ff)) return CLS_NORM;
    if (f == 52'h0) return CLS_INF;
    return (d ? w[51] : w[22]) ? CLS_SNAN : CLS_QNAN;
  endfunction
  function automatic logic [11:0] exp_f(input logic [63:0] w, input bit d);
    if (d) return 12'(w[62:52] == 11'h000 ? DP_EMIN : int'(w[62:52]) - DP_BIAS);
    return 12'(w[30:23] == 8'h00 ? SP_EMIN : int'(w[30:23]) - SP_BIAS);
  endfunction
  function automatic int lat_f(input fdu_op_t op, input fdu_fmt_t fm, input logic [63:0] a,
                               input logic [63:0] b);
    bit d, qa, qb;
    d = (fm == FMT_D);
    qa = !(cls_f(a, d) inside {CLS_NORM, CLS_SUB});
    qb = !(cls_f(b, d) inside {CLS_NORM, CLS_SUB});
    case (op)
      OP_CVT: return LAT_CVT;
      OP_MEDIA, OP_OTHER: return LAT_OTHER;
      OP_DIV: return (qa || qb) ? DIV_MIN : (d && (a[28:0] | b[28:0]) != 0) ? DIV_MAX : DIV_MID;
      OP_SQRT: return qa ? SQRT_MIN : (d && a[28:0] != 0) ? SQRT_MAX : SQRT_MID;
      default: return LAT_ARITH;
    endcase
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic ret(input logic [7:0] g, input bit u);
    chk(pend[g], 1'b1);
    chk(u, uexp[g]);
    if (exact[g]) chk(cyc, due[g]);
    else chk(cyc >= due[g], 1'b1);
    pend[g] = 1'b0;
    npend--;
  endtask
  task automatic send(input fdu_op_t op, input fdu_fmt_t fm, input logic [63:0] a,
                      input logic [63:0] b, input bit ex, input int lt);
    bit sh;
    sh = op inside {OP_ADD, OP_SUB, OP_MUL, OP_MADD, OP_MSUB, OP_MEDIA};
    uexp[tag_n] = sh & tog;
    tog ^= sh;
    lat[tag_n] = lat_f(op, fm, a, b);
    late[tag_n] = lt;
    exact[tag_n] = ex;
    pend[tag_n] = 1'b1;
    npend++;
    iss.push(op, fm, tag_n, a, b);
    tag_n++;
  endtask
  task automatic drain();
    for (int n = 0; n < 300 && npend != 0; n++) @(posedge clock);
    chk(npend, 0);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------
  // monitor: takes, classes, write-backs
  // ----------------
  always @(posedge clock) begin
    if (cls_pend) begin
      chk(a_cls_lo, e_alo);
      chk(a_cls_hi, e_ahi);
      chk(b_cls_lo, e_blo);
      chk(a_exp_lo, e_exp);
    end
    cls_pend = 1'b0;
    saw_stall |= (stall === 1'b1);
    if (issue_valid && issue_ready === 1'b1) begin
      due[issue_tag] = cyc + lat[issue_tag] + 1 + late[issue_tag];
      tk[issue_tag] = cyc;
      e_alo = cls_f(issue_a, issue_fmt == FMT_D);
      e_ahi = (issue_fmt == FMT_PS) ? cls_f({32'h0, issue_a[63:32]}, 1'b0) : e_alo;
      e_blo = cls_f(issue_b, issue_fmt == FMT_D);
      e_exp = exp_f(issue_a, issue_fmt == FMT_D);
      cls_pend = 1'b1;
    end
    if (wb_full_valid === 1'b1) ret(wb_full_tag, 1'b0);
    if (wb_am_valid === 1'b1) ret(wb_am_tag, 1'b1);
    cyc++;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    test_done();
  end
  // main sequence
  initial begin
    void'($urandom(95));
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    // every op alone, exact latency and unit
    for (int i = 0; i < 10; i++) begin
      send(fdu_op_t'(i), FMT_S, 64'h3f800000, 64'h40000000, 1'b1, 0);
      drain();
    end
    // operand classes and data-dependent divide and root
    for (int i = 0; i < 6; i++) begin
      send(OP_DIV, FMT_PS, {sv[5 - i], sv[i]}, {32'h0, sv[2]}, 1'b1, 0);
      drain();
      send(OP_SQRT, FMT_S, {32'h0, sv[i]}, 64'h0, 1'b1, 0);
      drain();
    end
    for (int i = 0; i < 4; i++) begin
      send(OP_DIV, FMT_D, dv[i], dv[0], 1'b1, 0);
      drain();
      send(OP_SQRT, FMT_D, dv[i], dv[0], 1'b1, 0);
      drain();
    end
    // back-to-back pipelined ops
    t = tag_n;
    for (int i = 0; i < 6; i++) send(fdu_op_t'(i % 5), FMT_S, 64'h3f800000, 64'h0, 1'b1, 0);
    drain();
    chk(tk[t + 5] - tk[t], 5);
    // same-cycle finish in the full unit
    slow = 1'b1;
    send(OP_ADD, FMT_S, 64'h3f800000, 64'h0, 1'b1, 1);
    send(OP_CVT, FMT_S, 64'h3f800000, 64'h0, 1'b1, 0);
    drain();
    // two divides in a row
    slow = 1'b0;
    t = tag_n;
    send(OP_DIV, FMT_S, 64'h3f800000, 64'h40000000, 1'b0, 0);
    send(OP_DIV, FMT_S, 64'h3f800000, 64'h40000000, 1'b0, 0);
    send(OP_ADD, FMT_S, 64'h3f800000, 64'h0, 1'b0, 0);
    drain();
    chk(saw_stall, 1'b1);
    chk(tk[t + 2] > due[t], 1'b1);
    // random traffic
    for (int i = 0; i < 60; i++) begin
      slow = 1'($urandom);
      send(fdu_op_t'($urandom % 10), fdu_fmt_t'($urandom % 3), {$urandom, $urandom},
           {$urandom, $urandom}, 1'b0, 0);
      repeat ($urandom % 3) @(posedge clock);
    end
    drain();
    test_done();
  end
endmodule
